// *** fss_dev.sv ***
// Purpose: status device end: latched fault flags and the read answers
// Assumes: condition inputs come from logic on pclk, so they pass no synchroniser
// Notes:   a read word is snapshot at the request so both bytes match
//
// The APB slave port was decided locally.
`default_nettype none
module fss_dev #(
    parameter logic [7:0] CLR_CODE = fss_pkg::CMD_FAULT_CLEAR
) (
    input  wire logic       pclk,            // clock
    input  wire logic       presetn,         // async reset, active low
    fss_link_if.dev         lnk,             // link to the host
    input  wire logic       busy_in,         // device busy
    input  wire logic       switch_off_in,   // pass switch turned off
    input  wire logic       vin_uv_flt_in,   // input undervoltage fault
    input  wire logic       thermal_any_in,  // some thermal register bit set
    input  wire logic       comms_any_in,    // some comms error bit set
    input  wire logic       vendor_any_in,   // some vendor register bit set
    input  wire logic       other_lo_in,     // event outside low byte bits
    input  wire logic       other_hi_in,     // event outside word bits 15:1
    input  wire logic       power_ok,        // power good, high when good
    input  wire logic       output_low_voltage_warn_in, // output low-voltage warning
    input  wire logic [7:0] input_cond_in,   // raw input conditions
    output logic      [15:0] summary_word_o, // registered copy of the word
    output logic            faults_cleared_o // pulse after a fault clear
);
    // ------------------------------------------------------------
    // raw set sources per byte
    // ------------------------------------------------------------
    logic [7:0] low_set;
    logic [7:0] out_set;
    logic [7:0] in_set;
    logic [7:0] low_now;
    logic [7:0] low_lat_ff;
    logic [7:0] out_ff;
    logic [7:0] in_ff;
    logic       other_hi_ff;
    logic       clr_ff;

    // map conditions onto their bit positions
    always_comb begin
        low_set = 8'h00;
        low_set[fss_pkg::LB_BUSY]    = busy_in;
        low_set[fss_pkg::LB_SWOFF]   = switch_off_in;
        low_set[fss_pkg::LB_VINUV]   = vin_uv_flt_in;
        low_set[fss_pkg::LB_THERMAL] = thermal_any_in;
        low_set[fss_pkg::LB_COMMS]   = comms_any_in;
        low_set[fss_pkg::LB_OTHER]   = other_lo_in;
        out_set = 8'h00;
        out_set[fss_pkg::OC_UVWARN]  = output_low_voltage_warn_in;
        in_set  = input_cond_in & fss_pkg::IN_LATCH_MASK;
    end

    // ------------------------------------------------------------
    // sticky flags
    // ------------------------------------------------------------
    // hold or set one byte; a set in the clear cycle wins, so a fault still present survives
    function automatic logic [7:0] hold_set(
        input logic [7:0] src,
        input logic [7:0] q,
        input logic       clr,
        input logic [7:0] keep
    );
        return (src | (q & ~{8{clr}})) & keep;
    endfunction

    // positions outside a mask stay zero in the flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_lat_ff  <= 8'h00;
            out_ff      <= 8'h00;
            in_ff       <= 8'h00;
            other_hi_ff <= 1'b0;
        end else begin
            low_lat_ff  <= hold_set(low_set, low_lat_ff, clr_ff, fss_pkg::LOW_LATCH_MASK);
            out_ff      <= hold_set(out_set, out_ff, clr_ff, fss_pkg::OUT_LATCH_MASK);
            in_ff       <= hold_set(in_set, in_ff, clr_ff, fss_pkg::IN_LATCH_MASK);
            other_hi_ff <= other_hi_in | (other_hi_ff & ~clr_ff);
        end
    end

    // thermal and comms bits mirror their own detail registers
    assign low_now = low_lat_ff | (low_set & ~fss_pkg::LOW_LATCH_MASK);

    // ------------------------------------------------------------
    // summary word assembly
    // ------------------------------------------------------------
    // built from live ORs, so aggregate bits drop the same cycle as detail
    function automatic logic [15:0] build_word(
        input logic [7:0] lo,
        input logic [7:0] oc,
        input logic [7:0] ic,
        input logic       vend,
        input logic       pok,
        input logic       oth
    );
        logic [15:0] w;
        w = {8'h00, lo};
        w[fss_pkg::SW_OUTPUT] = |oc;
        w[fss_pkg::SW_OUTCUR] = |fss_pkg::OUTCUR_VALUE;
        w[fss_pkg::SW_INPUT]  = |ic;
        w[fss_pkg::SW_VENDOR] = vend;
        w[fss_pkg::SW_PGOODN] = ~pok;
        w[fss_pkg::SW_OTHER]  = oth;
        return w;                                       // bits 10:9 stay zero
    endfunction

    logic [15:0] word_now;
    assign word_now = build_word(low_now, out_ff, in_ff, vendor_any_in, power_ok, other_hi_ff);

    // registered copy for the local side
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            summary_word_o <= 16'h0000;
        end else begin
            summary_word_o <= word_now;
        end
    end

    // ------------------------------------------------------------
    // command handling
    // ------------------------------------------------------------
    fss_pkg::fss_dev_state_t state_ff;
    logic [7:0] hi_byte_ff;
    logic       rsp_valid_ff;
    logic [7:0] rsp_byte_ff;
    logic       rsp_last_ff;
    logic       rsp_nack_ff;

    // fault clear strobe; writes to status codes fall through and touch nothing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clr_ff <= 1'b0;
        end else begin
            clr_ff <= lnk.req & lnk.is_write & (lnk.code == CLR_CODE);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            faults_cleared_o <= 1'b0;
        end else begin
            faults_cleared_o <= clr_ff;
        end
    end

    // answer sequencer: first byte the cycle after the request
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff     <= fss_pkg::FSS_IDLE;
            hi_byte_ff   <= 8'h00;
            rsp_valid_ff <= 1'b0;
            rsp_byte_ff  <= 8'h00;
            rsp_last_ff  <= 1'b0;
            rsp_nack_ff  <= 1'b0;
        end else begin
            rsp_valid_ff <= 1'b0;
            rsp_last_ff  <= 1'b0;
            rsp_nack_ff  <= 1'b0;
            rsp_byte_ff  <= 8'h00;
            case (state_ff)
                fss_pkg::FSS_IDLE: begin
                    if (lnk.req) begin
                        rsp_valid_ff <= 1'b1;
                        rsp_last_ff  <= 1'b1;
                        if (lnk.is_write) begin
                            // only the clear code is acknowledged and acts; other writes get nack
                            rsp_nack_ff <= (lnk.code != CLR_CODE);
                        end else begin
                            case (lnk.code)
                                fss_pkg::CMD_SUMMARY_WORD: begin
                                    rsp_byte_ff <= word_now[7:0];
                                    hi_byte_ff  <= word_now[15:8];
                                    rsp_last_ff <= 1'b0;
                                    state_ff    <= fss_pkg::FSS_HIGH;
                                end
                                fss_pkg::CMD_OUTPUT_COND: begin
                                    rsp_byte_ff <= out_ff;
                                end
                                fss_pkg::CMD_OUTCUR_COND: begin
                                    rsp_byte_ff <= fss_pkg::OUTCUR_VALUE;
                                end
                                fss_pkg::CMD_INPUT_COND: begin
                                    rsp_byte_ff <= in_ff;
                                end
                                default: begin
                                    rsp_nack_ff <= 1'b1;
                                end
                            endcase
                        end
                    end
                end
                fss_pkg::FSS_HIGH: begin
                    // requests here break the one-outstanding contract and get no answer; a clear write still acts
                    rsp_valid_ff <= 1'b1;
                    rsp_byte_ff  <= hi_byte_ff;
                    rsp_last_ff  <= 1'b1;
                    state_ff     <= fss_pkg::FSS_IDLE;
                end
                default: begin
                    state_ff <= fss_pkg::FSS_IDLE;
                end
            endcase
        end
    end

    // link outputs straight from flops
    assign lnk.rsp_valid = rsp_valid_ff;
    assign lnk.rsp_byte  = rsp_byte_ff;
    assign lnk.rsp_last  = rsp_last_ff;
    assign lnk.rsp_nack  = rsp_nack_ff;
endmodule
`default_nettype wire

// *** fss_pkg.sv ***
// Purpose: shared constants for the fault status summary link and both of its ends
// Assumes: one clock pclk at 250 MHz, active-low asynchronous reset presetn
// Notes:   command codes, bit positions and host register offsets live here only
//
// Overview of operation
// - Code 79h answers two-byte summary word.
// - Flags hold until cause gone and cleared.
// - Word low byte is the summary byte.
// - Bits 15-12 OR detailed; bit 11 inverts power_ok.
// - Bit 8 other event; bits 10:9 zero.
// - Code 7Ah answers output condition byte.
// - Output bit 5 low-voltage warning; rest zero.
// - Code 7Bh answers all-zero current byte.
// - Code 7Ch answers input condition byte.
// - Host uses summary to pick detailed reads.
// - Low byte: busy, switch off, UV, thermal, comms, other.
// - Input byte: OV, UV, OC, OP flags; bit 3 zero.
`default_nettype none
package fss_pkg;
    // ------------------------------------------------------------
    // link command codes
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_SUMMARY_WORD = 8'h79;
    localparam logic [7:0] CMD_OUTPUT_COND  = 8'h7A;
    localparam logic [7:0] CMD_OUTCUR_COND  = 8'h7B;
    localparam logic [7:0] CMD_INPUT_COND   = 8'h7C;
    localparam logic [7:0] CMD_FAULT_CLEAR  = 8'h03;
    // ------------------------------------------------------------
    // summary word fields
    // ------------------------------------------------------------
    localparam int SW_OUTPUT  = 15;
    localparam int SW_OUTCUR  = 14;
    localparam int SW_INPUT   = 13;
    localparam int SW_VENDOR  = 12;
    localparam int SW_PGOODN  = 11;
    localparam int SW_OTHER   = 8;
    localparam int LB_BUSY    = 7;
    localparam int LB_SWOFF   = 6;
    localparam int LB_VINUV   = 3;
    localparam int LB_THERMAL = 2;
    localparam int LB_COMMS   = 1;
    localparam int LB_OTHER   = 0;
    localparam int OC_UVWARN  = 5;
    // latched bits of each byte; the others are live or reserved
    localparam logic [7:0] LOW_LATCH_MASK = 8'hC9;
    localparam logic [7:0] OUT_LATCH_MASK = 8'h20;
    localparam logic [7:0] IN_LATCH_MASK  = 8'hF7;
    localparam logic [7:0] OUTCUR_VALUE   = 8'h00;
    // ------------------------------------------------------------
    // host controller registers (byte offsets on APB)
    // ------------------------------------------------------------
    localparam logic [7:0] HR_CTRL     = 8'h00;
    localparam logic [7:0] HR_STAT     = 8'h04;
    localparam logic [7:0] HR_RDATA    = 8'h08;
    localparam logic [7:0] HR_IRQ_STAT = 8'h0C;
    localparam logic [7:0] HR_IRQ_MASK = 8'h10;
    localparam int CTRL_CODE_LSB  = 0;
    localparam int CTRL_WDATA_LSB = 8;
    localparam int CTRL_WRITE     = 16;
    localparam int CTRL_GO        = 31;
    localparam int STAT_BUSY      = 0;
    localparam int STAT_NACK      = 1;
    localparam int IRQ_DONE       = 0;
    localparam int IRQ_NACK       = 1;
    localparam logic [1:0] IRQ_RESET = 2'h0;
    // answer states of the device end
    typedef enum logic [1:0] {
        FSS_IDLE = 2'b01,
        FSS_HIGH = 2'b10
    } fss_dev_state_t;
endpackage
`default_nettype wire

// *** fss_link_if.sv ***
// Purpose: command and answer link between host controller and status device
// Assumes: both ends on pclk; one request outstanding at a time
// Notes:   answers come one byte per pulse, low byte first, last byte marked
`default_nettype none
interface fss_link_if;
    logic       req;      // host: one-cycle request strobe
    logic [7:0] code;     // host: command code
    logic       is_write; // host: write (send byte) instead of read
    logic [7:0] wdata;    // host: write data byte
    logic       rsp_valid; // dev: one-cycle byte strobe
    logic [7:0] rsp_byte;  // dev: answer byte
    logic       rsp_last;  // dev: last byte of the answer
    logic       rsp_nack;  // dev: code not known or write not to clear code, with the last strobe
    modport dev  (input req, code, is_write, wdata, output rsp_valid, rsp_byte, rsp_last, rsp_nack);
    modport host (output req, code, is_write, wdata, input rsp_valid, rsp_byte, rsp_last, rsp_nack);
endinterface
`default_nettype wire

// *** fss_host.sv ***
// Purpose: host controller end: APB registers drive link commands
// Assumes: software polls busy or waits for the done interrupt before the next go
// Notes:   APB answers with one wait state; unmapped offsets give pslverr
`default_nettype none
module fss_host (
    input  wire logic        pclk,    // clock
    input  wire logic        presetn, // async reset, active low
    input  wire logic        psel,    // APB select
    input  wire logic        penable, // APB enable
    input  wire logic        pwrite,  // APB direction
    input  wire logic [7:0]  paddr,   // APB byte address
    input  wire logic [31:0] pwdata,  // APB write data
    output logic      [31:0] prdata,  // APB read data
    output logic             pready,  // APB ready
    output logic             pslverr, // APB error
    output logic             irq,     // level interrupt
    fss_link_if.host         lnk      // link to the device
);
    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------
    logic        acc;
    logic        wr_take;
    logic        mapped;
    logic [31:0] rd_mux;
    logic [15:0] rdata_ff;
    logic        busy_ff;
    logic        nack_ff;
    logic [1:0]  irq_stat_ff;
    logic [1:0]  irq_mask_ff;
    logic        got_lo_ff;

    assign acc     = psel & penable;
    assign wr_take = acc & pready & pwrite;

    // read mux and address decode
    always_comb begin
        mapped = 1'b1;
        rd_mux = 32'h0000_0000;
        case (paddr)
            fss_pkg::HR_CTRL:     rd_mux = 32'h0000_0000;
            fss_pkg::HR_STAT:     rd_mux = {30'h0, nack_ff, busy_ff};
            fss_pkg::HR_RDATA:    rd_mux = {16'h0000, rdata_ff};
            fss_pkg::HR_IRQ_STAT: rd_mux = {30'h0, irq_stat_ff};
            fss_pkg::HR_IRQ_MASK: rd_mux = {30'h0, irq_mask_ff};
            default:              mapped = 1'b0;
        endcase
    end

    // one wait state keeps prdata and pready on flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= acc & ~pready;
            prdata  <= rd_mux;
            pslverr <= acc & ~pready & ~mapped;
        end
    end

    // ------------------------------------------------------------
    // link command issue
    // ------------------------------------------------------------
    logic       go;
    logic       req_ff;
    logic [7:0] code_ff;
    logic       is_write_ff;
    logic [7:0] wdata_ff;

    // a go while busy is ignored, so a command never overlaps an answer
    assign go = wr_take & (paddr == fss_pkg::HR_CTRL) & pwdata[fss_pkg::CTRL_GO] & ~busy_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_ff      <= 1'b0;
            code_ff     <= 8'h00;
            is_write_ff <= 1'b0;
            wdata_ff    <= 8'h00;
        end else begin
            req_ff <= go;
            if (go) begin
                code_ff     <= pwdata[fss_pkg::CTRL_CODE_LSB +: 8];
                wdata_ff    <= pwdata[fss_pkg::CTRL_WDATA_LSB +: 8];
                is_write_ff <= pwdata[fss_pkg::CTRL_WRITE];
            end
        end
    end

    assign lnk.req      = req_ff;
    assign lnk.code     = code_ff;
    assign lnk.is_write = is_write_ff;
    assign lnk.wdata    = wdata_ff;

    // ------------------------------------------------------------
    // answer collection
    // ------------------------------------------------------------
    // low byte first; summary bits then tell software which detail to read next
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_ff   <= 1'b0;
            nack_ff   <= 1'b0;
            rdata_ff  <= 16'h0000;
            got_lo_ff <= 1'b0;
        end else begin
            if (go) begin
                busy_ff   <= 1'b1;
                nack_ff   <= 1'b0;
                rdata_ff  <= 16'h0000;
                got_lo_ff <= 1'b0;
            end else if (lnk.rsp_valid && busy_ff) begin
                if (got_lo_ff) begin
                    rdata_ff[15:8] <= lnk.rsp_byte;
                end else begin
                    rdata_ff[7:0] <= lnk.rsp_byte;
                end
                got_lo_ff <= 1'b1;
                if (lnk.rsp_last) begin
                    busy_ff <= 1'b0;
                    nack_ff <= lnk.rsp_nack;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // interrupts
    // ------------------------------------------------------------
    logic [1:0] irq_ev;
    assign irq_ev = {lnk.rsp_valid & lnk.rsp_last & lnk.rsp_nack & busy_ff,
                     lnk.rsp_valid & lnk.rsp_last & busy_ff};

    // write one to clear; a new event in the same cycle wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_ff <= fss_pkg::IRQ_RESET;
        end else begin
            irq_stat_ff <= irq_ev | (irq_stat_ff &
                ~((wr_take && paddr == fss_pkg::HR_IRQ_STAT) ? pwdata[1:0] : 2'h0));
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask_ff <= fss_pkg::IRQ_RESET;
        end else if (wr_take && paddr == fss_pkg::HR_IRQ_MASK) begin
            irq_mask_ff <= pwdata[1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |((irq_ev | irq_stat_ff) & irq_mask_ff);
        end
    end
endmodule
`default_nettype wire

// *** fss_link_monitor.sv ***
// Purpose: checker for the status link between the host end and the device end
// Assumes: one clock pclk, active-low asynchronous reset presetn
// Notes:   link signals only; flag contents are left to the bench
`default_nettype none
module fss_link_monitor (
    input wire logic       pclk,      // clock
    input wire logic       presetn,   // async reset, active low
    input wire logic       req,       // request strobe
    input wire logic [7:0] code,      // command code
    input wire logic       is_write,  // write request
    input wire logic [7:0] wdata,     // write byte
    input wire logic       rsp_valid, // answer byte strobe
    input wire logic [7:0] rsp_byte,  // answer byte
    input wire logic       rsp_last,  // last answer byte
    input wire logic       rsp_nack   // refused request
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // -----------------------------------------------
    // request decode
    // -----------------------------------------------
    // one strobe per read kind ties each answer to its cause
    wire logic rd   = req && !is_write;
    wire logic rd_w = rd && code == fss_pkg::CMD_SUMMARY_WORD;
    wire logic rd_o = rd && code == fss_pkg::CMD_OUTPUT_COND;
    wire logic rd_c = rd && code == fss_pkg::CMD_OUTCUR_COND;
    wire logic rd_i = rd && code == fss_pkg::CMD_INPUT_COND;
    wire logic clr  = req && is_write && code == fss_pkg::CMD_FAULT_CLEAR;
    wire logic wbad = req && is_write && code != fss_pkg::CMD_FAULT_CLEAR;
    // -----------------------------------------------
    // answer shape
    // -----------------------------------------------
    a_word_two_bytes: assert property (rd_w |=> rsp_valid && !rsp_last ##1 rsp_valid && rsp_last && !rsp_nack)
        else $error("word answer is not two bytes");
    a_word_reserved_zero: assert property (rd_w |=> rsp_byte[5:4] == 2'h0 ##1 rsp_byte[2:1] == 2'h0 && !rsp_byte[6])
        else $error("reserved word bits set");
    a_out_byte: assert property (rd_o |=> rsp_valid && rsp_last && !rsp_nack && (rsp_byte & 8'hDF) == 8'h00)
        else $error("output condition answer wrong");
    a_outcur_zero: assert property (rd_c |=> rsp_valid && rsp_last && !rsp_nack && rsp_byte == 8'h00)
        else $error("current condition not zero");
    a_input_byte: assert property (rd_i |=> rsp_valid && rsp_last && !rsp_nack && !rsp_byte[3])
        else $error("input condition answer wrong");
    a_write_refused: assert property (wbad |=> rsp_valid && rsp_last && rsp_nack && rsp_byte == 8'h00)
        else $error("status write not refused");
    a_clear_acked: assert property (clr |=> rsp_valid && rsp_last && !rsp_nack)
        else $error("fault clear not acknowledged");
    a_no_stray_byte: assert property (rsp_valid |-> $past(req) || ($past(rsp_valid) && !$past(rsp_last)))
        else $error("answer byte without request");
    cover property (rd_w);
    cover property (wbad && wdata == 8'h00);
    cover property (clr);
endmodule
`default_nettype wire

// *** testbench.sv ***
// Purpose: self-checking bench joining host end and device end over the link
// Assumes: APB answers after wait states; the bench waits on pready and busy, bounded
// Notes:   link answers are collected by a watcher and matched against queued expectations
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, fclr;
    logic busy, swoff, vuv, therm, comms, vend, olo, ohi, pok, ouv, have;
    logic [7:0]  paddr, ic, icx, lo;
    logic [31:0] pwdata, prdata, r;
    logic [15:0] sw;
    logic        er;
    logic [15:0] exp_q[$];
    int failures = 0, cmp_count = 0, seed = 66, nclr = 0;
    fss_link_if lnk();
    fss_host i_fss_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .lnk(lnk));
    fss_dev i_fss_dev (.pclk(pclk), .presetn(presetn), .lnk(lnk), .busy_in(busy), .switch_off_in(swoff),
        .vin_uv_flt_in(vuv), .thermal_any_in(therm), .comms_any_in(comms), .vendor_any_in(vend),
        .other_lo_in(olo), .other_hi_in(ohi), .power_ok(pok), .output_low_voltage_warn_in(ouv), .input_cond_in(ic),
        .summary_word_o(sw), .faults_cleared_o(fclr));
    fss_link_monitor i_fss_link_monitor (.pclk(pclk), .presetn(presetn), .req(lnk.req), .code(lnk.code),
        .is_write(lnk.is_write), .wdata(lnk.wdata), .rsp_valid(lnk.rsp_valid), .rsp_byte(lnk.rsp_byte),
        .rsp_last(lnk.rsp_last), .rsp_nack(lnk.rsp_nack));
    // ------------------------------------------------
    // compare and closing tasks
    // ------------------------------------------------
    task chk_reg(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH t=%0t register got %h exp %h", $time, g, e);
        end
    endtask
    task chk_ans(input logic [15:0] g, input logic [15:0] e);
        cmp_count++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH t=%0t answer got %h exp %h", $time, g, e);
        end
    endtask
    task end_sim;
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // ------------------------------------------------
    // bus master: entered just after a rising edge
    // ------------------------------------------------
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
        r = prdata; er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge pclk);
        if (n >= 50) failures++;
    endtask
    // one link command: queue the answer, go, poll busy, check nack and read data
    task cmd(input logic [7:0] c, input logic w, input logic [15:0] e, input logic nk);
        int n;
        exp_q.push_back(e);
        apb(1'b1, fss_pkg::HR_CTRL, {1'b1, 14'h0, w, 8'h00, c});
        n = 0;
        do begin apb(1'b0, fss_pkg::HR_STAT, 32'h0); n++; end while (r[0] !== 1'b0 && n < 20);
        if (r[0] !== 1'b0) failures++;
        chk_reg({31'h0, r[1]}, {31'h0, nk});
        if (!w && !nk) begin
            apb(1'b0, fss_pkg::HR_RDATA, 32'h0);
            chk_reg(c == 8'h79 ? r & 32'hFFFF : r & 32'hFF, {16'h0, e});
            if (c == 8'h79) chk_reg({16'h0, sw}, {16'h0, e});
        end
    endtask
    // ------------------------------------------------
    // clock, watchdog, answer watcher
    // ------------------------------------------------
    initial begin pclk = 1'b0; forever #2 pclk = ~pclk; end
    always @(posedge pclk) if (fclr === 1'b1) nclr++;
    initial begin #200000; failures++; end_sim; end
    // bytes are paired here; a lone last byte is a single-byte answer
    initial begin
        have = 1'b0; lo = 8'h00;
        forever begin
            @(posedge pclk);
            if (lnk.rsp_valid === 1'b1 && !have && lnk.rsp_last !== 1'b1) begin lo = lnk.rsp_byte; have = 1'b1; end
            else if (lnk.rsp_valid === 1'b1) begin
                if (exp_q.size() == 0) chk_ans(16'hDEAD, 16'h0);
                else chk_ans(have ? {lnk.rsp_byte, lo} : {8'h00, lnk.rsp_byte}, exp_q.pop_front());
                have = 1'b0;
            end
        end
    end
    // ------------------------------------------------
    // main sequence
    // ------------------------------------------------
    initial begin
        {presetn, psel, penable, pwrite, busy, swoff, vuv, therm, comms, vend, olo, ohi, pok, ouv} = 14'h0;
        paddr = 8'h00; pwdata = 32'h0; ic = 8'h00;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, fss_pkg::HR_IRQ_MASK, 32'h0);
        chk_reg(r, 32'h0);
        apb(1'b0, 8'h20, 32'h0);
        chk_reg({31'h0, er}, 32'h1);
        $display("reset and map test done");
        // every cause raised, then latched ones dropped: flags must hold
        {busy, swoff, vuv, therm, comms, vend, olo, ohi, ouv} <= 9'h1FF;
        ic <= 8'($random(seed));
        repeat (3) @(posedge pclk);
        {busy, swoff, vuv, olo, ohi, ouv} <= 6'h0;
        icx = ic & 8'hF7;
        ic <= 8'h00;
        @(posedge pclk);
        cmd(8'h79, 1'b0, {2'b10, |icx, 5'h19, 8'hCF}, 1'b0);
        chk_reg({31'h0, irq}, 32'h0);
        cmd(8'h7A, 1'b0, 16'h0020, 1'b0);
        cmd(8'h7B, 1'b0, 16'h0000, 1'b0);
        cmd(8'h7C, 1'b0, {8'h00, icx}, 1'b0);
        cmd(8'h7C, 1'b1, 16'h0000, 1'b1);
        cmd(8'h7C, 1'b0, {8'h00, icx}, 1'b0);
        cmd(8'h55, 1'b0, 16'h0000, 1'b1);
        $display("latched flag test done");
        // clear while busy cause still high: that flag survives
        {busy, therm, comms, vend, pok} <= 5'h11;
        cmd(fss_pkg::CMD_FAULT_CLEAR, 1'b1, 16'h0000, 1'b0);
        cmd(8'h79, 1'b0, 16'h0080, 1'b0);
        busy <= 1'b0;
        cmd(fss_pkg::CMD_FAULT_CLEAR, 1'b1, 16'h0000, 1'b0);
        cmd(8'h79, 1'b0, 16'h0000, 1'b0);
        chk_reg(nclr, 32'h2);
        $display("fault clear test done");
        // done is sticky; unmasking raises the line, a one clears it
        apb(1'b1, fss_pkg::HR_IRQ_MASK, 32'h1);
        repeat (2) @(posedge pclk);
        chk_reg({31'h0, irq}, 32'h1);
        apb(1'b1, fss_pkg::HR_IRQ_STAT, 32'h3);
        apb(1'b0, fss_pkg::HR_IRQ_STAT, 32'h0);
        chk_reg(r, 32'h0);
        chk_reg({31'h0, irq}, 32'h0);
        $display("interrupt test done");
        end_sim;
    end
endmodule
`default_nettype wire
